// >>> design/dccr_pkg.sv
// Constants shared by the code and shared-configuration register bank.
// Assumes a 32-bit AXI4-Lite bus whose byte address is four times the register index.
package dccr_pkg;

  // Register indices; the byte address is the index times four.
  localparam int          ADDR_W   = 8;
  localparam logic [5:0]  IDX_CH2  = 6'h19;
  localparam logic [5:0]  IDX_CH0  = 6'h1B;
  localparam logic [5:0]  IDX_CH1  = 6'h1C;
  localparam logic [5:0]  IDX_CFG  = 6'h1F;
  localparam logic [5:0]  IDX_KEY  = 6'h20;
  localparam logic [5:0]  CH_IDX [3] = '{IDX_CH0, IDX_CH1, IDX_CH2};

  // Code register layout: stored field is bits 15..4, the code is its upper ten bits.
  localparam int          CODE_LSB = 4;
  localparam int          CODE_W   = 10;
  localparam logic [11:0] CODE_RST = 12'h000;

  // Shared configuration fields.
  localparam int          CFG_WIN  = 15;
  localparam int          CFG_LOCK = 14;
  localparam int          CFG_ROW  = 13;
  localparam int          CFG_REF  = 12;
  localparam int          CFG_PD1  = 10;
  localparam int          CFG_PD0  = 7;
  localparam int          CFG_PD2  = 1;
  localparam int          CH_PD_LSB [3] = '{CFG_PD0, CFG_PD1, CFG_PD2};
  localparam logic [15:0] CFG_RST  = 16'h0FFF;

  // Unlock key held in bits 15..12 of the key register.
  localparam int          KEY_LSB  = 12;
  localparam logic [3:0]  KEY_VAL  = 4'h5;

  // Fault-dump rows.
  localparam logic [7:0]  ROW_ZERO = 8'h00;
  localparam logic [7:0]  ROW_ONE  = 8'h01;

  // One-hot output stage modes.
  localparam int          PD_W     = 5;
  localparam int          PD_UP    = 0;
  localparam int          PD_R10K  = 1;
  localparam int          PD_R100K = 2;
  localparam int          PD_HIZ   = 3;
  localparam int          PD_R1K2  = 4;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

endpackage : dccr_pkg

// >>> design/dccr_win_hold.sv
// Window-comparator output stage: transparent or holding.
// Assumes cmp_i arrives from the analog comparator, asynchronous to clk_i.
`timescale 1ns/1ps
module dccr_win_hold import dccr_pkg::*; (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic cmp_i,
  input  wire logic sel_i,
  input  wire logic clr_i,
  output logic      hold_o
);
  logic sync1_reg;
  logic sync2_reg;
  logic hold_next;

  // A held output keeps its state until cleared; a new hit beats the clear.
  assign hold_next = sel_i ? (sync2_reg | (hold_o & ~clr_i)) : sync2_reg;

  // Two flops guard against metastability on the comparator level.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      hold_o    <= 1'b0;
    end else begin
      sync1_reg <= cmp_i;
      sync2_reg <= sync1_reg;
      hold_o    <= hold_next;
    end
  end

  // Transparent mode tracks the synchronised comparison one cycle later.
  a_follow_input: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !sel_i |=> hold_o == $past(sync2_reg)) else $error("Transparent output lost the comparison.");
  a_latch_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sel_i && hold_o && !clr_i |=> hold_o) else $error("Held output dropped without a clear.");
  c_latched: cover property (@(posedge clk_i) disable iff (!rstn_i)
    sel_i && hold_o && !sync2_reg ##1 hold_o);

endmodule : dccr_win_hold

// >>> design/dccr_pd_decode.sv
// Decodes one channel's two-bit power state into a registered one-hot stage mode.
// Assumes state_i comes from a register on the same clock.
`timescale 1ns/1ps
module dccr_pd_decode import dccr_pkg::*; #(
  parameter bit LOW_R_ONLY = 1'b0
) (
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic [1:0]      state_i,
  output logic      [PD_W-1:0] pd_o
);
  logic [PD_W-1:0] pd_next;
  localparam logic [PD_W-1:0] PD_RST = LOW_R_ONLY ? PD_W'(1 << PD_R1K2) : PD_W'(1 << PD_HIZ);

  // The low-resistance channel has one pull-down for every non-zero code.
  always_comb begin
    pd_next = '0;
    if (LOW_R_ONLY) begin
      pd_next[state_i == 2'h0 ? PD_UP : PD_R1K2] = 1'b1;
    end else begin
      unique case (state_i)
        2'h0: pd_next[PD_UP]    = 1'b1;
        2'h1: pd_next[PD_R10K]  = 1'b1;
        2'h2: pd_next[PD_R100K] = 1'b1;
        2'h3: pd_next[PD_HIZ]   = 1'b1;
      endcase
    end
  end

  // Reset matches the configuration reset, so the stage starts powered down.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_o <= PD_RST;
    end else begin
      pd_o <= pd_next;
    end
  end

  a_pd_up: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_i == 2'h0) |=> pd_o == PD_W'(1 << PD_UP)) else $error("Channel not powered up on code zero.");
  a_pd_down: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state_i != 2'h0) && LOW_R_ONLY |=> pd_o[PD_R1K2]) else $error("Low-resistance pull-down missing.");

endmodule : dccr_pd_decode

// >>> design/dccr_top.sv
// Output-code and shared-configuration register bank behind an AXI4-Lite slave.
// Assumes one clock; the window comparator level comes from outside this domain.
// Function
// - Channel codes are unsigned straight binary.
// - All code registers reset to zero.
// - Shared configuration resets to 0FFFh.
// - Bit 15: transparent or holding comparator output.
// - Lock bit blocks code writes and all configuration writes but a keyed unlock.
// - Bit 13 selects fault-dump row 0 or 1.
// - Bit 12 enables the internal reference.
// - Bits 11..10 set channel one power state.
// - Bits 8..7 set channel zero power state.
// - Bits 2..1: channel two up or 1.2k.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module dccr_top import dccr_pkg::*; (
  input  wire logic              MCLK_I,
  input  wire logic              RSTN_I,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic [2:0]        S_AXI_AWPROT_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic      [1:0]        S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic [2:0]        S_AXI_ARPROT_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic      [31:0]       S_AXI_RDATA_O,
  output logic      [1:0]        S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  input  wire logic              WIN_CMP_I,
  input  wire logic              WIN_CLR_I,
  output logic                   WIN_OUT_O,
  output logic      [CODE_W-1:0] CH0_CODE_O,
  output logic      [CODE_W-1:0] CH1_CODE_O,
  output logic      [CODE_W-1:0] CH2_CODE_O,
  output logic      [PD_W-1:0]   CH0_PD_O,
  output logic      [PD_W-1:0]   CH1_PD_O,
  output logic      [PD_W-1:0]   CH2_PD_O,
  output logic                   LOCK_O,
  output logic                   REF_EN_O,
  output logic      [7:0]        FAULT_ROW_O
);

  // True when a byte address is aligned and points at the given register.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
  endfunction : hit

  // Merges the two low byte lanes of a write into an old 16-bit value.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
                                        input logic [1:0] strb);
    merge = {strb[1] ? dat[15:8] : old[15:8], strb[0] ? dat[7:0] : old[7:0]};
  endfunction : merge

  // Write channel state.
  logic              have_aw_reg;
  logic              have_w_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [15:0]       wdata_reg;
  logic [1:0]        wstrb_reg;
  logic              aw_fire;
  logic              w_fire;
  logic              wr_do;
  logic              have_aw_next;
  logic              have_w_next;
  logic              bvalid_next;
  logic [1:0]        bresp_next;

  // Read channel state.
  logic              ar_fire;
  logic              rvalid_next;
  logic [15:0]       rd_val;
  logic              rd_map;

  // Register contents.
  logic [11:0]       code_reg [3];
  logic [15:0]       cfg_reg;
  logic              key_armed_reg;
  logic [15:0]       cfg_wval;
  logic              locked;
  logic              w_cfg;
  logic              w_key;
  logic              w_map;
  logic              cfg_we;
  logic              blocked;
  logic [2:0]        code_we;
  logic [2:0]        w_code;
  logic [PD_W-1:0]   pd_w [3];

  // Handshakes: each channel moves one item when valid and ready meet.
  assign aw_fire = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  assign w_fire  = S_AXI_WVALID_I & S_AXI_WREADY_O;
  assign ar_fire = S_AXI_ARVALID_I & S_AXI_ARREADY_O;

  // A write is carried out once both halves are held and no response is pending.
  assign wr_do        = have_aw_reg & have_w_reg & ~S_AXI_BVALID_O;
  assign have_aw_next = (have_aw_reg | aw_fire) & ~wr_do;
  assign have_w_next  = (have_w_reg | w_fire) & ~wr_do;
  assign bvalid_next  = wr_do | (S_AXI_BVALID_O & ~S_AXI_BREADY_I);
  assign rvalid_next  = ar_fire | (S_AXI_RVALID_O & ~S_AXI_RREADY_I);

  // Address decode of the held write.
  assign w_cfg   = wr_do & hit(awaddr_reg, IDX_CFG);
  assign w_key   = wr_do & hit(awaddr_reg, IDX_KEY);
  assign w_map   = w_cfg | w_key | (|w_code);
  assign locked  = cfg_reg[CFG_LOCK];

  // Per-channel code write enables; a locked bank ignores them.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      logic [15:0] code_wval;

      assign w_code[g]  = wr_do & hit(awaddr_reg, CH_IDX[g]);
      assign code_we[g] = w_code[g] & ~locked;
      // The merged word needs a name, since a function result cannot be sliced.
      assign code_wval  = merge({code_reg[g], 4'h0}, wdata_reg, wstrb_reg);

      // Code field bits 15..4 are kept; the low nibble is dropped on write.
      always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          code_reg[g] <= CODE_RST;
        end else if (code_we[g]) begin
          code_reg[g] <= code_wval[15:CODE_LSB];
        end
      end

      // Each channel's power field drives its own output stage decoder.
      dccr_pd_decode #(
        .LOW_R_ONLY (g == 2)
      ) u_pd (
        .clk_i   (MCLK_I),
        .rstn_i  (RSTN_I),
        .state_i (cfg_reg[CH_PD_LSB[g] +: 2]),
        .pd_o    (pd_w[g])
      );
    end
  endgenerate

  // Locked configuration accepts only an armed write that clears the lock.
  assign cfg_wval = merge(cfg_reg, wdata_reg, wstrb_reg);
  assign cfg_we   = w_cfg & (~locked | (key_armed_reg & ~cfg_wval[CFG_LOCK]));
  assign blocked  = ((|w_code) & locked) | (w_cfg & ~cfg_we);
  assign bresp_next = ~w_map ? RESP_DECERR : (blocked ? RESP_SLVERR : RESP_OKAY);

  // Read decode; unmapped reads answer zero with a decode error.
  assign rd_map = hit(S_AXI_ARADDR_I, IDX_CH0) | hit(S_AXI_ARADDR_I, IDX_CH1) |
                  hit(S_AXI_ARADDR_I, IDX_CH2) | hit(S_AXI_ARADDR_I, IDX_CFG) |
                  hit(S_AXI_ARADDR_I, IDX_KEY);
  assign rd_val = hit(S_AXI_ARADDR_I, IDX_CH0) ? {code_reg[0], 4'h0} :
                  hit(S_AXI_ARADDR_I, IDX_CH1) ? {code_reg[1], 4'h0} :
                  hit(S_AXI_ARADDR_I, IDX_CH2) ? {code_reg[2], 4'h0} :
                  hit(S_AXI_ARADDR_I, IDX_CFG) ? cfg_reg :
                  hit(S_AXI_ARADDR_I, IDX_KEY) ? {key_armed_reg ? KEY_VAL : 4'h0, 12'h000} :
                  16'h0000;

  // Write channel: hold the address and data halves until both are present.
  // Ready drops while a response waits, so a second write cannot overtake it.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      have_aw_reg     <= 1'b0;
      have_w_reg      <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
    end else begin
      have_aw_reg     <= have_aw_next;
      have_w_reg      <= have_w_next;
      S_AXI_AWREADY_O <= ~have_aw_next & ~bvalid_next;
      S_AXI_WREADY_O  <= ~have_w_next & ~bvalid_next;
      S_AXI_BVALID_O  <= bvalid_next;
    end
  end

  // Payload captures for the held write and its response.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      awaddr_reg    <= '0;
      wdata_reg     <= 16'h0000;
      wstrb_reg     <= 2'h0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awaddr_reg <= S_AXI_AWADDR_I;
      end
      if (w_fire) begin
        wdata_reg <= S_AXI_WDATA_I[15:0];
        wstrb_reg <= S_AXI_WSTRB_I[1:0];
      end
      if (wr_do) begin
        S_AXI_BRESP_O <= bresp_next;
      end
    end
  end

  // Read channel: one read in flight; data are sampled when the address is taken.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY_O <= ~rvalid_next;
      S_AXI_RVALID_O  <= rvalid_next;
      if (ar_fire) begin
        S_AXI_RDATA_O <= {16'h0000, rd_val};
        S_AXI_RRESP_O <= rd_map ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // Shared configuration; reserved bits are stored as written.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_reg <= CFG_RST;
    end else if (cfg_we) begin
      cfg_reg <= cfg_wval;
    end
  end

  // The key arms only the next configuration write, which always disarms it.
  // Keeping the arm one-shot stops a stale key from unlocking much later.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      key_armed_reg <= 1'b0;
    end else if (w_key) begin
      key_armed_reg <= wstrb_reg[1] & (wdata_reg[KEY_LSB +: 4] == KEY_VAL);
    end else if (w_cfg) begin
      key_armed_reg <= 1'b0;
    end
  end

  // Pin-side copies of configuration fields and codes, one cycle behind the registers.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      LOCK_O      <= 1'b0;
      REF_EN_O    <= 1'b0;
      FAULT_ROW_O <= ROW_ZERO;
      CH0_CODE_O  <= '0;
      CH1_CODE_O  <= '0;
      CH2_CODE_O  <= '0;
    end else begin
      LOCK_O      <= cfg_reg[CFG_LOCK];
      REF_EN_O    <= cfg_reg[CFG_REF];
      FAULT_ROW_O <= cfg_reg[CFG_ROW] ? ROW_ONE : ROW_ZERO;
      CH0_CODE_O  <= code_reg[0][11:2];
      CH1_CODE_O  <= code_reg[1][11:2];
      CH2_CODE_O  <= code_reg[2][11:2];
    end
  end

  assign CH0_PD_O = pd_w[0];
  assign CH1_PD_O = pd_w[1];
  assign CH2_PD_O = pd_w[2];

  // Comparator output stage.
  dccr_win_hold u_win (
    .clk_i  (MCLK_I),
    .rstn_i (RSTN_I),
    .cmp_i  (WIN_CMP_I),
    .sel_i  (cfg_reg[CFG_WIN]),
    .clr_i  (WIN_CLR_I),
    .hold_o (WIN_OUT_O)
  );

  // Marks the first clock edge after reset release for the reset checks.
  logic seen_reg;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= 1'b1;
    end
  end

  a_reset_codes: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !seen_reg |-> code_reg[0] == 12'h000 && code_reg[1] == 12'h000 && code_reg[2] == 12'h000)
    else $error("Code register not zero after reset.");
  a_reset_config: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !seen_reg |-> cfg_reg == 16'h0FFF && CH0_PD_O[PD_HIZ] && CH2_PD_O[PD_R1K2])
    else $error("Configuration not at its reset value.");
  a_low_nibble: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    ar_fire && (hit(S_AXI_ARADDR_I, IDX_CH0) || hit(S_AXI_ARADDR_I, IDX_CH2))
    |=> S_AXI_RDATA_O[3:0] == 4'h0) else $error("Code read shows low nibble.");
  a_code_output: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    code_we[1] && wstrb_reg == 2'h3 |=> ##1 CH1_CODE_O == $past(wdata_reg[15:6], 2))
    else $error("Channel one code does not follow its write.");
  a_lock_codes: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    locked |=> $stable(code_reg[0]) && $stable(code_reg[1]) && $stable(code_reg[2]))
    else $error("Code changed while locked.");
  a_lock_config: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    locked && !key_armed_reg |=> $stable(cfg_reg)) else $error("Configuration changed while locked.");
  a_lock_error: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    (|w_code) && locked |=> S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_SLVERR)
    else $error("Locked write not refused.");
  a_row_select: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    $changed(cfg_reg[CFG_ROW]) |=> FAULT_ROW_O == {7'h00, $past(cfg_reg[CFG_ROW])})
    else $error("Fault-dump row not following its select.");
  a_ref_enable: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    cfg_we && wstrb_reg[1] |=> ##1 REF_EN_O == $past(wdata_reg[CFG_REF], 2))
    else $error("Reference enable not following its write.");
  a_pd_channel1: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    cfg_reg[11:10] == 2'h2 |=> CH1_PD_O == 5'h04) else $error("Channel one 100k mode missing.");
  a_pd_channel0: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    cfg_reg[8:7] == 2'h1 |=> CH0_PD_O == 5'h02) else $error("Channel zero 10k mode missing.");
  a_write_resp: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    wr_do |=> S_AXI_BVALID_O && !S_AXI_AWREADY_O) else $error("Write response late.");

  // Read timing, the key, channel two's stage, the lock pin and open code writes, each of which a stale value could hide.
  a_read_resp: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    ar_fire |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("Read response late.");
  a_key_oneshot: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    w_cfg |=> !key_armed_reg) else $error("Key survived a configuration write.");
  a_unlock_key: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    locked && cfg_we |-> key_armed_reg) else $error("Lock cleared without the key.");
  a_pd_channel2: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    cfg_reg[2:1] == 2'h2 |=> CH2_PD_O == 5'h10) else $error("Channel two pull-down missing.");
  a_lock_output: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    locked |=> LOCK_O) else $error("Lock pin not following its bit.");
  a_code_taken: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    (|w_code) && !locked |=> S_AXI_BRESP_O == RESP_OKAY) else $error("Open code write refused.");

  c_unlock: cover property (@(posedge MCLK_I) disable iff (!RSTN_I)
    locked && key_armed_reg && cfg_we ##1 !locked);
  c_code_write: cover property (@(posedge MCLK_I) disable iff (!RSTN_I) code_we[0]);
  c_locked_refusal: cover property (@(posedge MCLK_I) disable iff (!RSTN_I) w_cfg && !cfg_we);
  c_unmapped_read: cover property (@(posedge MCLK_I) disable iff (!RSTN_I) ar_fire && !rd_map);

endmodule : dccr_top

// >>> bench/dccr_host_model.sv
// Host model: an AXI4-Lite master that drives the register bank.
// Assumes one clock; the bench calls its tasks by hierarchical name.
`timescale 1ns/1ps
module dccr_host_model import dccr_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              awready_i,
  input  wire logic              wready_i,
  input  wire logic [1:0]        bresp_i,
  input  wire logic              bvalid_i,
  input  wire logic              arready_i,
  input  wire logic [31:0]       rdata_i,
  input  wire logic [1:0]        rresp_i,
  input  wire logic              rvalid_i,
  output logic      [ADDR_W-1:0] awaddr_o,
  output logic      [2:0]        awprot_o,
  output logic                   awvalid_o,
  output logic      [31:0]       wdata_o,
  output logic      [3:0]        wstrb_o,
  output logic                   wvalid_o,
  output logic                   bready_o,
  output logic      [ADDR_W-1:0] araddr_o,
  output logic      [2:0]        arprot_o,
  output logic                   arvalid_o,
  output logic                   rready_o
);
  // Everything idle at time zero.
  initial begin
    {awaddr_o, awprot_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arprot_o, arvalid_o, rready_o} = '0;
  end

  // One write; released payloads are inverted so a stale value is never mistaken for a live one.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, output logic [1:0] r);
    logic aw_on;
    logic w_on;
    @(posedge clk_i);
    awaddr_o  <= a;
    awprot_o  <= 3'($urandom());
    wdata_o   <= {16'h0000, d};
    wstrb_o   <= 4'h3;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    aw_on = 1'b1;
    w_on  = 1'b1;
    while (aw_on || w_on) begin
      @(posedge clk_i);
      if (aw_on && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a;
        aw_on = 1'b0;
      end
      if (w_on && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~wdata_o;
        w_on = 1'b0;
      end
    end
    do @(posedge clk_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr

  // One read; the answer is taken at the edge where rvalid is seen high.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d, output logic [1:0] r);
    logic ar_on;
    @(posedge clk_i);
    araddr_o  <= a;
    arprot_o  <= 3'($urandom());
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    ar_on = 1'b1;
    do begin
      @(posedge clk_i);
      if (ar_on && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
        ar_on = 1'b0;
      end
    end while (ar_on || !rvalid_i);
    d = rdata_i[15:0];
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd

  // Unlock sequence: key first, then the configuration write that clears the lock bit.
  task automatic unlock(input logic [3:0] key, input logic [15:0] cfg, output logic [1:0] r);
    wr({IDX_KEY, 2'b00}, {key, 12'h000}, r);
    wr({IDX_CFG, 2'b00}, cfg, r);
  endtask : unlock
endmodule : dccr_host_model

// >>> bench/testbench.sv
// Self-checking bench for the code and shared-configuration register bank.
// Assumes the host model drives the AXI4-Lite side; the comparator pins are driven here.
`timescale 1ns/1ps
module testbench import dccr_pkg::*; ;
  localparam logic [7:0] A_CFG = {IDX_CFG, 2'b00};
  logic mclk = 1'b0, rstn = 1'b0, cmp = 1'b0, clr = 1'b0;
  logic [ADDR_W-1:0] awa, ara;
  logic [2:0] awp, arp;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, wout, lock, ref_en;
  logic [1:0] bresp, rresp;
  logic [CODE_W-1:0] code [3];
  logic [PD_W-1:0] pd [3];
  logic [7:0] row;
  logic [15:0] last [3];
  int n_errors = 0, num_checks = 0;

  // 40 MHz clock.
  always #12.5 mclk = ~mclk;

  dccr_top DUT (.MCLK_I(mclk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(awp),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(arp), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rr), .WIN_CMP_I(cmp), .WIN_CLR_I(clr), .WIN_OUT_O(wout),
    .CH0_CODE_O(code[0]), .CH1_CODE_O(code[1]), .CH2_CODE_O(code[2]), .CH0_PD_O(pd[0]),
    .CH1_PD_O(pd[1]), .CH2_PD_O(pd[2]), .LOCK_O(lock), .REF_EN_O(ref_en), .FAULT_ROW_O(row));

  dccr_host_model host (.clk_i(mclk), .awready_i(awr), .wready_i(wrd), .bresp_i(bresp),
    .bvalid_i(bv), .arready_i(arr), .rdata_i(rdat), .rresp_i(rresp), .rvalid_i(rv),
    .awaddr_o(awa), .awprot_o(awp), .awvalid_o(awv), .wdata_o(wd), .wstrb_o(ws),
    .wvalid_o(wv), .bready_o(br), .araddr_o(ara), .arprot_o(arp), .arvalid_o(arv), .rready_o(rr));

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Reserved fields are always written as ones, as software must.
  function automatic logic [15:0] cfg_word(input logic [3:0] t, input logic [1:0] p1, p0, p2);
    return {t, p1, 1'b1, p0, 4'hF, p2, 1'b1};
  endfunction : cfg_word

  // Expected one-hot stage mode; channel two only knows up or the low resistor.
  function automatic logic [4:0] pd_exp(input int ch, input logic [1:0] st);
    return (ch == 2) ? ((st == 2'h0) ? 5'h01 : 5'h10) : 5'h01 << st;
  endfunction : pd_exp

  function automatic logic [7:0] ach(input int i);
    return {CH_IDX[i], 2'b00};
  endfunction : ach

  // Outputs trail the register by a cycle or two, so a short settle precedes their checks.
  task automatic check_cfg(input logic [15:0] c);
    logic [15:0] d;
    logic [1:0] r;
    host.rd(A_CFG, d, r);
    chk(d, c, "cfg readback");
    repeat (4) @(posedge mclk);
    chk(pd[0], pd_exp(0, c[8:7]), "ch0 stage");
    chk(pd[1], pd_exp(1, c[11:10]), "ch1 stage");
    chk(pd[2], pd_exp(2, c[2:1]), "ch2 stage");
    chk(ref_en, c[12], "reference");
    chk(row, c[13] ? ROW_ONE : ROW_ZERO, "dump row");
    chk(lock, c[14], "lock");
  endtask : check_cfg

  task automatic win_step(input logic v, input logic cl, input logic exp);
    @(posedge mclk);
    cmp <= v;
    clr <= cl;
    repeat (6) @(posedge mclk);
    chk(wout, exp, "window out");
  endtask : win_step

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Watchdog, well beyond the few hundred cycles the tests need.
  initial begin
    #500000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict;
  end

  initial begin
    logic [15:0] d, c;
    logic [1:0] r;
    void'($urandom(32'hECF1));
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    check_cfg(CFG_RST);
    for (int i = 0; i < 3; i++) begin
      host.rd(ach(i), d, r);
      chk(d, 16'h0000, "code reset");
      last[i] = 16'h0000;
    end
    $display("test reset done");
    for (int n = 0; n < 24; n++) begin
      d = (n < 3) ? 16'hFFFF : 16'($urandom());
      host.wr(ach(n % 3), d, r);
      chk(r, RESP_OKAY, "code write");
      host.rd(ach(n % 3), c, r);
      chk(c, d & 16'hFFF0, "code readback");
      last[n % 3] = d & 16'hFFF0;
      repeat (3) @(posedge mclk);
      chk(code[n % 3], d[15:6], "code out");
    end
    $display("test codes done");
    for (int s = 0; s < 4; s++) begin
      c = cfg_word({2'b00, s[0], s[1]}, s[1:0], 2'(s + 1), 2'(3 - s));
      host.wr(A_CFG, c, r);
      check_cfg(c);
    end
    $display("test config done");
    host.wr(A_CFG, cfg_word(4'h0, 2'h0, 2'h0, 2'h0), r);
    win_step(1'b1, 1'b0, 1'b1);
    win_step(1'b0, 1'b0, 1'b0);
    host.wr(A_CFG, cfg_word(4'h8, 2'h0, 2'h0, 2'h0), r);
    win_step(1'b1, 1'b0, 1'b1);
    win_step(1'b0, 1'b0, 1'b1);
    win_step(1'b0, 1'b1, 1'b0);
    win_step(1'b1, 1'b1, 1'b1);
    $display("test window done");
    c = cfg_word(4'h4, 2'h1, 2'h2, 2'h0);
    host.wr(A_CFG, c, r);
    check_cfg(c);
    host.wr(ach(0), 16'h1230, r);
    chk(r, RESP_SLVERR, "locked code write");
    host.rd(ach(0), d, r);
    chk(d, last[0], "locked code kept");
    host.wr(A_CFG, cfg_word(4'h0, 2'h0, 2'h0, 2'h0), r);
    chk(r, RESP_SLVERR, "unlock without key");
    host.unlock(4'h6, cfg_word(4'h0, 2'h0, 2'h0, 2'h0), r);
    chk(r, RESP_SLVERR, "unlock wrong key");
    c = cfg_word(4'h1, 2'h2, 2'h1, 2'h3);
    host.unlock(KEY_VAL, c, r);
    chk(r, RESP_OKAY, "unlock with key");
    check_cfg(c);
    $display("test lock done");
    for (int i = 0; i < 3; i++) begin
      host.wr(8'h00 + 8'(i * 5), 16'hFFFF, r);
      chk(r, RESP_DECERR, "unmapped write");
      host.rd(8'h00 + 8'(i * 5), d, r);
      chk({r, d}, {RESP_DECERR, 16'h0000}, "unmapped read");
    end
    $display("test unmapped done");
    print_verdict;
  end
endmodule : testbench
